// *** bench/cpc_chroma_regs_checker.sv ***
`timescale 1ns/100ps
module cpc_chroma_regs_checker
   import cpc_pkg::*;
(
   input wire logic mclk,
   input wire logic rstn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic sampleStrobe,
   input wire cpc_ctl_s chromaCtl,
   input wire logic realTimeControlOutput
);
   // ****
   // Bus and control properties
   // ****
   default clocking dc @(posedge mclk);
   endclocking
   default disable iff (!rstn);
   a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
      else $error("read response dropped early");
   a_read_latency: assert property (s_axi_arvalid && s_axi_arready
      |=> s_axi_rvalid)
      else $error("read answer late");
   a_write_latency: assert property (s_axi_awvalid && s_axi_awready
      && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
      else $error("write answer late");
   a_aw_blocked: assert property (s_axi_bvalid
      |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted during response");
   a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read accepted during response");
   a_rdata_pad: assert property (s_axi_rvalid
      |-> s_axi_rdata[31:8] == 24'h0)
      else $error("upper read bits not zero");
   a_std_legal: assert property (!(chromaCtl.colourStandardSelect
      inside {CPC_STD_RES6, CPC_STD_RES7}))
      else $error("reserved standard reached chroma path");
   a_slot_hold: assert property (!realTimeControlOutput
      && !sampleStrobe |=> !realTimeControlOutput)
      else $error("slot low shorter than a sample");
   c_write: cover property (s_axi_bvalid && s_axi_bready);
   c_read: cover property (s_axi_rvalid && s_axi_rready);
   c_slot: cover property ($fell(realTimeControlOutput));
endmodule

bind cpc_chroma_regs cpc_chroma_regs_checker u_chk (.mclk, .rstn,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
   .s_axi_rready, .sampleStrobe, .chromaCtl, .realTimeControlOutput);

// *** bench/cpc_chroma_regs_tb.sv ***
`timescale 1ns/100ps
module cpc_chroma_regs_tb
   import cpc_pkg::*;
;
   localparam logic [7:0] A1 = 8'(CPC_OFF_CTL_ONE);
   localparam logic [7:0] A2 = 8'(CPC_OFF_GAIN);
   localparam logic [7:0] A3 = 8'(CPC_OFF_CTL_TWO);
   logic mclk, rstn, sampleStrobe, activeLine, lineRate60;
   logic [7:0] s_axi_awaddr, s_axi_araddr, burstAmplitude;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb;
   logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
   logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid, realTimeControlOutput;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs;
   logic [15:0] phaseStep, subcarrierPhase;
   logic [9:0] blueIn, redIn;
   logic [11:0] blueOut, redOut;
   cpc_ctl_s chromaCtl;
   int mismatches, num_checks;

   cpc_chroma_regs #(.PHASE_W(16)) u_dut (.mclk, .rstn, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .sampleStrobe, .activeLine, .lineRate60, .phaseStep, .burstAmplitude,
      .blueIn, .redIn, .blueOut, .redOut, .chromaCtl, .subcarrierPhase,
      .realTimeControlOutput);

   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   // ****
   // Shared tasks
   // ****
   task automatic check(input string nm, input logic [31:0] s,
      input logic [31:0] e);
      num_checks++;
      if (s !== e) begin
         mismatches++;
         $display("[ERR] %s expected %0h seen %0h", nm, e, s);
      end
   endtask

   task automatic close_out();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic hang();
      mismatches++;
      close_out();
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic aw, w, b;
      aw = 1'b0;
      w = 1'b0;
      b = 1'b0;
      @(posedge mclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (int n = 0; n < 20 && !b; n++) begin
         @(negedge mclk);
         aw = aw || s_axi_awready === 1'b1;
         w = w || s_axi_wready === 1'b1;
         b = s_axi_bvalid === 1'b1;
         rs = s_axi_bresp;
         @(posedge mclk);
         if (aw) s_axi_awvalid <= 1'b0;
         if (w) s_axi_wvalid <= 1'b0;
         if (b) s_axi_bready <= 1'b0;
      end
      if (!b) hang();
   endtask

   task automatic rdr(input logic [7:0] a);
      logic ar, r;
      ar = 1'b0;
      r = 1'b0;
      @(posedge mclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (int n = 0; n < 20 && !r; n++) begin
         @(negedge mclk);
         ar = ar || s_axi_arready === 1'b1;
         r = s_axi_rvalid === 1'b1;
         rd = s_axi_rdata;
         rs = s_axi_rresp;
         @(posedge mclk);
         if (ar) s_axi_arvalid <= 1'b0;
         if (r) s_axi_rready <= 1'b0;
      end
      if (!r) hang();
   endtask

   task automatic stb(input int k);
      repeat (k) begin
         @(posedge mclk);
         sampleStrobe <= 1'b1;
         @(posedge mclk);
         sampleStrobe <= 1'b0;
      end
      repeat (2) @(posedge mclk);
      @(negedge mclk);
   endtask

   // ****
   // Scenarios
   // ****
   task automatic t_reset();
      rdr(A1);
      check("rst one", rd, {24'h0, CPC_RST_CTL_ONE});
      rdr(A2);
      check("rst gain", rd, {24'h0, CPC_RST_GAIN});
      rdr(A3);
      check("rst two", rd, {24'h0, CPC_RST_CTL_TWO});
      $display("done reset");
   endtask

   task automatic t_std();
      logic [7:0] v;
      wr(A2, 32'hA4);
      activeLine <= 1'b1;
      for (int c = 0; c < 6; c++) begin
         v = {1'b0, 3'(c), c[0], c[1], 1'b0, c[2]};
         @(posedge mclk);
         lineRate60 <= (c == 4);
         wr(A1, {24'h0, v});
         stb(1);
         check("std", chromaCtl.colourStandardSelect, c);
         check("vf", chromaCtl.chromaVfilterOn, !c[0]);
         check("fast_colour_time_constant", chromaCtl.fastColourTimeConstant, c[1]);
         check("comb", chromaCtl.adaptiveChromaCombEnable, c[2]);
         rdr(A1);
         check("rb one", rd, {24'h0, v});
      end
      rdr(8'(CPC_OFF_STATUS));
      check("seen stds", rd[5:0], 6'h3F);
      $display("done standards");
   endtask

   task automatic t_gain();
      logic [7:0] g [4] = '{8'h80, 8'h24, 8'hFF, 8'h11};
      logic [11:0] eb [4] = '{12'h2AA, 12'h5FE, 12'hFFC, 12'h5FE};
      logic [11:0] er [4] = '{12'h154, 12'h2FD, 12'hFFC, 12'h2FD};
      logic [7:0] p;
      p = 8'hA4;
      foreach (g[i]) begin
         wr(A2, {24'h0, g[i]});
         check("gain early", chromaCtl.chromaFixedGain, p[6:0]);
         stb(1);
         check("mode", chromaCtl.chromaGainMode, g[i][7]);
         check("gain", chromaCtl.chromaFixedGain, g[i][6:0]);
         rdr(A2);
         check("rb gain", rd, {24'h0, g[i]});
         stb(1);
         check("blue out", blueOut, eb[i]);
         check("red out", redOut, er[i]);
         p = g[i];
      end
      $display("done gain");
   endtask

   task automatic t_two();
      logic [7:0] v;
      for (int i = 0; i < 4; i++) begin
         v = {2'(i), ~2'(i), i[0], i[1], i[1], i[0]};
         wr(A3, {24'h0, v});
         stb(1);
         check("blue", chromaCtl.blueDiffFineOffset, v[7:6]);
         check("red", chromaCtl.redDiffFineOffset, v[5:4]);
         check("bw", chromaCtl.chromaBandwidthSelect, v[3]);
         check("trade", chromaCtl.lumaChromaBandwidthTrade, v[2:0]);
         rdr(A3);
         check("rb two", rd, {24'h0, v});
      end
      $display("done control two");
   endtask

   task automatic t_unmap();
      wr(8'h44, 32'hFF);
      check("wr err", rs, CPC_RESP_SLVERR);
      rdr(8'h44);
      check("rd err", rs, CPC_RESP_SLVERR);
      check("rd err data", rd, 32'h0);
      rdr(A3);
      check("kept two", rd, 32'hCF);
      check("ok resp", rs, CPC_RESP_OKAY);
      $display("done unmapped");
   endtask

   task automatic t_phase();
      int lows;
      lows = 0;
      @(posedge mclk);
      phaseStep <= 16'h1234;
      stb(3);
      check("phase run", subcarrierPhase, 16'h369C);
      @(posedge mclk);
      phaseStep <= 16'h0;
      wr(A1, 32'h80);
      stb(1);
      check("phase clr", subcarrierPhase, 16'h0);
      for (int k = 0; k < 130; k++) begin
         stb(1);
         if (realTimeControlOutput !== 1'b1) lows++;
      end
      check("slot lows", lows, 1);
      rdr(A1);
      check("clr kept", rd, 32'h80);
      $display("done phase clear");
   endtask

   initial begin
      mismatches = 0;
      num_checks = 0;
      rstn = 1'b0;
      sampleStrobe = 1'b0;
      activeLine = 1'b0;
      lineRate60 = 1'b0;
      s_axi_awaddr = 8'h0;
      s_axi_araddr = 8'h0;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hF;
      s_axi_awvalid = 1'b0;
      s_axi_wvalid = 1'b0;
      s_axi_bready = 1'b0;
      s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b0;
      burstAmplitude = 8'h80;
      phaseStep = 16'h0;
      blueIn = 10'h155;
      redIn = 10'h0AA;
      repeat (5) @(posedge mclk);
      rstn <= 1'b1;
      t_reset();
      t_std();
      t_gain();
      t_two();
      t_unmap();
      t_phase();
      close_out();
   end
endmodule

// *** rtl/cpc_chroma_path.sv ***
`timescale 1ns/100ps
// Chroma sample processing steered by the control registers
module cpc_chroma_path
   import cpc_pkg::*;
(
   input wire logic mclk,
   input wire logic rstn,
   input wire logic sampleStrobe,
   input wire cpc_ctl_s ctl,
   input wire logic activeLine,
   input wire logic [7:0] burstAmplitude,
   input wire logic [9:0] blueIn,
   input wire logic [9:0] redIn,
   output logic [11:0] blueOut,
   output logic [11:0] redOut
);
   typedef struct packed {
      logic [11:0] blue;
      logic [11:0] red;
      logic [11:0] bluePrev;
      logic [11:0] redPrev;
      logic [6:0] agcGain;
   } cpc_path_s;

   cpc_path_s s_q, s_d;
   logic [6:0] gain;
   logic [11:0] bScaled, rScaled;

   // Piecewise gain through 0.5, 1.125, 7.5 in quarter LSB units
   // Saturates below full scale to leave headroom for the offset
   function automatic logic [11:0] scale(input logic [9:0] v,
                                         input logic [6:0] g);
      logic [23:0] q;
      if (g <= 7'h24) begin
         q = (24'(v) * (24'h90 + 24'(g) * 24'h5)) / 24'h48;
      end else begin
         q = (24'(v) * (24'h333 + (24'(g) - 24'h24) * 24'h33)) / 24'hB6;
      end
      return (q > 24'hFFC) ? 12'hFFC : q[11:0];
   endfunction

   always_comb begin
      s_d = s_q;
      gain = ctl.chromaGainMode ? ctl.chromaFixedGain : s_q.agcGain;
      bScaled = scale(blueIn, gain);
      rScaled = scale(redIn, gain);
      if (sampleStrobe) begin
         if (burstAmplitude < 8'h80 && s_q.agcGain != 7'h7F) begin
            s_d.agcGain = s_q.agcGain + 7'h01;
         end else if (burstAmplitude > 8'h80 && s_q.agcGain != 7'h00) begin
            s_d.agcGain = s_q.agcGain - 7'h01;
         end
         // Quarter LSB offsets sit in two fraction bits
         s_d.blue = bScaled + 12'(ctl.blueDiffFineOffset);
         s_d.red = rScaled + 12'(ctl.redDiffFineOffset);
         if (ctl.chromaVfilterOn && activeLine) begin
            s_d.blue = 12'((13'(bScaled) + 13'(s_q.bluePrev)) >> 1)
                     + 12'(ctl.blueDiffFineOffset);
            s_d.red = 12'((13'(rScaled) + 13'(s_q.redPrev)) >> 1)
                    + 12'(ctl.redDiffFineOffset);
         end
         s_d.bluePrev = bScaled;
         s_d.redPrev = rScaled;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         s_q <= '{blue: '0, red: '0, bluePrev: '0, redPrev: '0,
                  agcGain: CPC_RST_GAIN[CPC_POS_GAIN +: 7]};
      end else begin
         s_q <= s_d;
      end
   end

   assign blueOut = s_q.blue;
   assign redOut = s_q.red;
endmodule

// *** rtl/cpc_chroma_regs.sv ***
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/100ps
module cpc_chroma_regs
   import cpc_pkg::*;
#(
   parameter int PHASE_W = 16
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic [CPC_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [CPC_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic sampleStrobe,
   input wire logic activeLine,
   input wire logic lineRate60,
   input wire logic [PHASE_W-1:0] phaseStep,
   input wire logic [7:0] burstAmplitude,
   input wire logic [9:0] blueIn,
   input wire logic [9:0] redIn,
   output logic [11:0] blueOut,
   output logic [11:0] redOut,
   output cpc_ctl_s chromaCtl,
   output logic [PHASE_W-1:0] subcarrierPhase,
   output logic realTimeControlOutput
);
   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      cpc_regs_s regs;
      cpc_ctl_s ctl;
      logic awHeld;
      logic [CPC_ADDR_W-1:0] awAddr;
      logic wHeld;
      logic [7:0] wData;
      logic wLane0;
      logic bValid;
      logic [1:0] bResp;
      logic rValid;
      logic [31:0] rData;
      logic [1:0] rResp;
      logic phaseClear;
      logic [7:0] seenStd;
      logic awRdy;
      logic wRdy;
      logic arRdy;
   } cpc_top_s;

   cpc_top_s s_q, s_d;
   logic [PHASE_W-1:0] dtoPhase;
   logic dtoRtco;
   logic [11:0] pathBlue, pathRed;

   function automatic logic addrHit(input logic [CPC_ADDR_W-1:0] a);
      return a == CPC_ADDR_W'(CPC_OFF_CTL_ONE)
          || a == CPC_ADDR_W'(CPC_OFF_GAIN)
          || a == CPC_ADDR_W'(CPC_OFF_CTL_TWO)
          || a == CPC_ADDR_W'(CPC_OFF_STATUS);
   endfunction

   function automatic cpc_ctl_s decode(input cpc_regs_s r,
                                       input logic rate60);
      cpc_ctl_s c;
      c.colourStandardSelect = cpc_std_e'(r.ctlOne[CPC_POS_STD +: 3]);
      c.chromaVfilterOn = ~r.ctlOne[CPC_POS_VF_DIS];
      c.fastColourTimeConstant = r.ctlOne[CPC_POS_FAST_TC];
      c.adaptiveChromaCombEnable = r.ctlOne[CPC_POS_COMB];
      c.chromaGainMode = r.gain[CPC_POS_GAIN_MODE];
      c.chromaFixedGain = r.gain[CPC_POS_GAIN +: 7];
      c.blueDiffFineOffset = r.ctlTwo[CPC_POS_BLUE_OFS +: 2];
      c.redDiffFineOffset = r.ctlTwo[CPC_POS_RED_OFS +: 2];
      c.chromaBandwidthSelect = r.ctlTwo[CPC_POS_BW];
      c.lumaChromaBandwidthTrade = r.ctlTwo[CPC_POS_TRADE +: 3];
      // Reserved and wrong-rate codes fall back to code 0
      if (c.colourStandardSelect inside {CPC_STD_RES6, CPC_STD_RES7}
          || (rate60 && c.colourStandardSelect == CPC_STD_SECAM)
          || (!rate60 && c.colourStandardSelect == CPC_STD_JAPAN)) begin
         c.colourStandardSelect = CPC_STD_A;
      end
      return c;
   endfunction

   // ****************************************************************
   // Bus slave and registers
   // ****************************************************************
   always_comb begin
      s_d = s_q;
      s_d.phaseClear = 1'b0;
      if (s_axi_awvalid && !s_q.awHeld && !s_q.bValid) begin
         s_d.awHeld = 1'b1;
         s_d.awAddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !s_q.wHeld && !s_q.bValid) begin
         s_d.wHeld = 1'b1;
         s_d.wData = s_axi_wdata[7:0];
         s_d.wLane0 = s_axi_wstrb[0];
      end
      if (s_q.awHeld && s_q.wHeld) begin
         s_d.awHeld = 1'b0;
         s_d.wHeld = 1'b0;
         s_d.bValid = 1'b1;
         s_d.bResp = addrHit(s_q.awAddr) ? CPC_RESP_OKAY : CPC_RESP_SLVERR;
         if (s_q.wLane0) begin
            case (s_q.awAddr)
               CPC_ADDR_W'(CPC_OFF_CTL_ONE): begin
                  s_d.regs.ctlOne = s_q.wData;
                  s_d.phaseClear = s_q.wData[CPC_POS_PHASE_CLEAR];
               end
               CPC_ADDR_W'(CPC_OFF_GAIN): begin
                  s_d.regs.gain = s_q.wData;
               end
               CPC_ADDR_W'(CPC_OFF_CTL_TWO): begin
                  s_d.regs.ctlTwo = s_q.wData;
               end
               default: begin
               end
            endcase
         end
      end
      if (s_q.bValid && s_axi_bready) begin
         s_d.bValid = 1'b0;
      end
      if (s_axi_arvalid && !s_q.rValid) begin
         s_d.rValid = 1'b1;
         s_d.rResp = addrHit(s_axi_araddr) ? CPC_RESP_OKAY : CPC_RESP_SLVERR;
         case (s_axi_araddr)
            CPC_ADDR_W'(CPC_OFF_CTL_ONE): s_d.rData = {24'h0, s_q.regs.ctlOne};
            CPC_ADDR_W'(CPC_OFF_GAIN): s_d.rData = {24'h0, s_q.regs.gain};
            CPC_ADDR_W'(CPC_OFF_CTL_TWO): s_d.rData = {24'h0, s_q.regs.ctlTwo};
            CPC_ADDR_W'(CPC_OFF_STATUS): s_d.rData = {24'h0, s_q.seenStd};
            default: s_d.rData = 32'h0000_0000;
         endcase
      end else if (s_q.rValid && s_axi_rready) begin
         s_d.rValid = 1'b0;
      end
      // Status: decoded standard's bit set every cycle, cleared only by reset
      s_d.seenStd = s_q.seenStd;
      s_d.seenStd[s_q.ctl.colourStandardSelect] = 1'b1;
      // Controls reach the path at the next sample
      if (sampleStrobe) begin
         s_d.ctl = decode(s_q.regs, lineRate60);
      end
      // Ready flags registered from the next state
      s_d.awRdy = !s_d.awHeld && !s_d.bValid;
      s_d.wRdy = !s_d.wHeld && !s_d.bValid;
      s_d.arRdy = !s_d.rValid;
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         s_q <= '0;
         s_q.regs <= '{ctlOne: CPC_RST_CTL_ONE, gain: CPC_RST_GAIN,
                       ctlTwo: CPC_RST_CTL_TWO};
         s_q.ctl <= decode('{ctlOne: CPC_RST_CTL_ONE, gain: CPC_RST_GAIN,
                             ctlTwo: CPC_RST_CTL_TWO}, 1'b0);
         s_q.awRdy <= 1'b1;
         s_q.wRdy <= 1'b1;
         s_q.arRdy <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // ****************************************************************
   // Chroma path and oscillator
   // ****************************************************************
   cpc_phase_dto #(.PHASE_W(PHASE_W)) u_dto (
      .mclk(mclk),
      .rstn(rstn),
      .sampleStrobe(sampleStrobe),
      .phaseStep(phaseStep),
      .phaseClear(s_q.phaseClear),
      .phase(dtoPhase),
      .realTimeControlOutput(dtoRtco)
   );

   cpc_chroma_path u_path (
      .mclk(mclk),
      .rstn(rstn),
      .sampleStrobe(sampleStrobe),
      .ctl(s_q.ctl),
      .activeLine(activeLine),
      .burstAmplitude(burstAmplitude),
      .blueIn(blueIn),
      .redIn(redIn),
      .blueOut(pathBlue),
      .redOut(pathRed)
   );

   assign s_axi_awready = s_q.awRdy;
   assign s_axi_wready = s_q.wRdy;
   assign s_axi_bvalid = s_q.bValid;
   assign s_axi_bresp = s_q.bResp;
   assign s_axi_arready = s_q.arRdy;
   assign s_axi_rvalid = s_q.rValid;
   assign s_axi_rdata = s_q.rData;
   assign s_axi_rresp = s_q.rResp;
   assign chromaCtl = s_q.ctl;
   assign subcarrierPhase = dtoPhase;
   assign realTimeControlOutput = dtoRtco;
   assign blueOut = pathBlue;
   assign redOut = pathRed;
endmodule

// *** rtl/cpc_phase_dto.sv ***
`timescale 1ns/100ps
// Subcarrier oscillator with phase clear and serial slot report
module cpc_phase_dto
   import cpc_pkg::*;
#(
   parameter int PHASE_W = 16
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic sampleStrobe,
   input wire logic [PHASE_W-1:0] phaseStep,
   input wire logic phaseClear,
   output logic [PHASE_W-1:0] phase,
   output logic realTimeControlOutput
);
   typedef struct packed {
      logic [PHASE_W-1:0] phase;
      logic [6:0] slot;
      logic clearPending;
      logic real_time_control_output;
   } cpc_dto_s;

   cpc_dto_s s_q, s_d;

   always_comb begin
      s_d = s_q;
      if (sampleStrobe) begin
         s_d.phase = s_q.phase + phaseStep;
         s_d.slot = s_q.slot + 7'h01;
         s_d.real_time_control_output = 1'b1;
         if (s_q.slot == 7'(CPC_SLOT_CLEAR) && s_q.clearPending) begin
            s_d.real_time_control_output = 1'b0;
            s_d.clearPending = 1'b0;
         end
      end
      if (phaseClear) begin
         s_d.phase = '0;
         s_d.clearPending = 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         s_q <= '{phase: '0, slot: 7'h00, clearPending: 1'b0, real_time_control_output: 1'b1};
      end else begin
         s_q <= s_d;
      end
   end

   assign phase = s_q.phase;
   assign realTimeControlOutput = s_q.real_time_control_output;
endmodule

// *** rtl/cpc_pkg.sv ***
package cpc_pkg;

   // ****************************************************************
   // Register indices and byte addresses
   // ****************************************************************
   localparam logic [7:0] CPC_INDEX_CTL_ONE = 8'h0E;
   localparam logic [7:0] CPC_INDEX_GAIN = 8'h0F;
   localparam logic [7:0] CPC_INDEX_CTL_TWO = 8'h10;
   localparam int CPC_ADDR_W = 8;
   localparam int CPC_OFF_CTL_ONE = 4 * CPC_INDEX_CTL_ONE;
   localparam int CPC_OFF_GAIN = 4 * CPC_INDEX_GAIN;
   localparam int CPC_OFF_CTL_TWO = 4 * CPC_INDEX_CTL_TWO;
   localparam int CPC_OFF_STATUS = 32'h0000_0050;

   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int CPC_POS_PHASE_CLEAR = 7;
   localparam int CPC_POS_STD = 4;
   localparam int CPC_POS_VF_DIS = 3;
   localparam int CPC_POS_FAST_TC = 2;
   localparam int CPC_POS_COMB = 0;
   localparam int CPC_POS_GAIN_MODE = 7;
   localparam int CPC_POS_GAIN = 0;
   localparam int CPC_POS_BLUE_OFS = 6;
   localparam int CPC_POS_RED_OFS = 4;
   localparam int CPC_POS_BW = 3;
   localparam int CPC_POS_TRADE = 0;

   // ****************************************************************
   // Reset values (neutral choice)
   // ****************************************************************
   localparam logic [7:0] CPC_RST_CTL_ONE = 8'h00;
   localparam logic [7:0] CPC_RST_GAIN = 8'h24;
   localparam logic [7:0] CPC_RST_CTL_TWO = 8'h00;

   // ****************************************************************
   // Timing and bus response codes
   // ****************************************************************
   localparam int CPC_SLOT_CLEAR = 68;
   localparam int CPC_SLOT_COUNT = 128;
   localparam logic [1:0] CPC_RESP_OKAY = 2'h0;
   localparam logic [1:0] CPC_RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      CPC_STD_A, CPC_STD_B, CPC_STD_C, CPC_STD_D,
      CPC_STD_JAPAN, CPC_STD_SECAM, CPC_STD_RES6, CPC_STD_RES7
   } cpc_std_e;

   // Decoded controls passed to the chroma path
   typedef struct packed {
      cpc_std_e colourStandardSelect;
      logic chromaVfilterOn;
      logic fastColourTimeConstant;
      logic adaptiveChromaCombEnable;
      logic chromaGainMode;
      logic [6:0] chromaFixedGain;
      logic [1:0] blueDiffFineOffset;
      logic [1:0] redDiffFineOffset;
      logic chromaBandwidthSelect;
      logic [2:0] lumaChromaBandwidthTrade;
   } cpc_ctl_s;

   typedef struct packed {
      logic [7:0] ctlOne;
      logic [7:0] gain;
      logic [7:0] ctlTwo;
   } cpc_regs_s;

endpackage
